/* File: core/oaq_alert_qualifier.sv */
// Operation
// - A 10 us comparison window runs freely without outside control.
// - Each window end compares the window average against the limit.
// - Windows ignore input edges; alert rises only at window ends.
// - The 50 us option asserts 40 us later than 10 us option.
// - The 100 us option asserts 90 us later than 10 us option.
// - Hysteresis pin: float 2 mV, ground 4 mV, supply 8 mV.
// - Alert is active low open drain, pulled low while flagged.
// - Latch pin low selects transparent mode where alert tracks input.
// - Transparent mode asserts alert when qualified input exceeds threshold.
// - Transparent mode releases alert after one full window below threshold minus hysteresis.
// - Delay pin: float 10 us, ground 50 us, supply 100 us.
// - Count consecutive over windows; any normal window clears the count.
// - Latched alert clears after latch low 20 us and input below.
// - Disabling clears the over-window count and alert; counting restarts from zero.
`timescale 1ns/1ps
`default_nettype none
module oaq_alert_qualifier #(
  parameter int unsigned SAMPLE_W = 18
) (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Front-end samples, same clock.
  input  wire logic [SAMPLE_W-1:0] vin_sample,
  input  wire logic [SAMPLE_W-1:0] limit_level,
  // Configuration pins.
  input  wire logic                enable_pin,
  input  wire logic                latch_select,
  input  wire logic [1:0]          delay_select,
  input  wire logic [1:0]          hysteresis_select,
  // Open-drain alert.
  output logic                     alert_n_o,
  output logic                     alert_n_oe,
  // Status.
  output logic                     window_tick,
  output logic                     window_over,
  output logic [3:0]               over_count
);

  localparam int unsigned SUM_W = SAMPLE_W + 12;

  if (SAMPLE_W < 18 || SAMPLE_W > 24) begin : g_bad_width
    $error("SAMPLE_W must lie between 18 and 24");
  end

  typedef struct packed {
    logic [2:0]          en_s;
    logic [2:0]          lt_s;
    logic [5:0]          dl_s;
    logic [5:0]          hy_s;
    logic                en_f;
    logic                lt_f;
    logic [1:0]          dl_f;
    logic [1:0]          hy_f;
    logic [10:0]         win_cnt;
    logic [SUM_W-1:0]    sum;
    logic [3:0]          cnt;
    logic                alert;
    logic                latched;
    logic [12:0]         low_cnt;
    logic                under;
    logic                tick;
    logic                over;
    logic                pin_o;
  } oaq_state_t;

  oaq_state_t state_reg;
  oaq_state_t state_next;

  function automatic logic [3:0] need_windows(input logic [1:0] lvl);
    case (lvl)
      oaq_pkg::LVL_GND:    need_windows = oaq_pkg::NEED_50US;
      oaq_pkg::LVL_SUPPLY: need_windows = oaq_pkg::NEED_100US;
      default:             need_windows = oaq_pkg::NEED_10US;
    endcase
  endfunction

  function automatic logic [17:0] hys_amount(input logic [1:0] lvl);
    case (lvl)
      oaq_pkg::LVL_GND:    hys_amount = oaq_pkg::HYS_4MV;
      oaq_pkg::LVL_SUPPLY: hys_amount = oaq_pkg::HYS_8MV;
      default:             hys_amount = oaq_pkg::HYS_2MV;
    endcase
  endfunction

  logic [SUM_W-1:0] total;
  logic [SUM_W-1:0] trip_sum;
  logic [SUM_W-1:0] rel_sum;
  logic [SAMPLE_W-1:0] hys_w;
  logic             win_end;
  logic             is_over;
  logic             is_under;
  logic [3:0]       need;

  always_comb begin
    state_next = state_reg;
    // Pins pass three flops; a change counts when the last two agree.
    state_next.en_s = {state_reg.en_s[1:0], enable_pin};
    state_next.lt_s = {state_reg.lt_s[1:0], latch_select};
    state_next.dl_s = {state_reg.dl_s[3:0], delay_select};
    state_next.hy_s = {state_reg.hy_s[3:0], hysteresis_select};
    if (state_reg.en_s[2] == state_reg.en_s[1]) begin
      state_next.en_f = state_reg.en_s[2];
    end
    if (state_reg.lt_s[2] == state_reg.lt_s[1]) begin
      state_next.lt_f = state_reg.lt_s[2];
    end
    if (state_reg.dl_s[5:4] == state_reg.dl_s[3:2]) begin
      state_next.dl_f = state_reg.dl_s[5:4];
    end
    if (state_reg.hy_s[5:4] == state_reg.hy_s[3:2]) begin
      state_next.hy_f = state_reg.hy_s[5:4];
    end
    need     = need_windows(state_reg.dl_f);
    hys_w    = SAMPLE_W'(hys_amount(state_reg.hy_f));
    win_end  = (state_reg.win_cnt == 11'(oaq_pkg::WIN_CYCLES - 1));
    total    = state_reg.sum + SUM_W'(vin_sample);
    trip_sum = SUM_W'(limit_level) * SUM_W'(oaq_pkg::WIN_CYCLES);
    rel_sum  = (limit_level > hys_w)
             ? SUM_W'(limit_level - hys_w) * SUM_W'(oaq_pkg::WIN_CYCLES)
             : '0;
    is_over  = (total > trip_sum);
    is_under = (total < rel_sum);
    // The window keeps running whether or not the part is enabled.
    state_next.win_cnt = win_end ? 11'h000 : state_reg.win_cnt + 11'h001;
    state_next.sum     = win_end ? '0 : total;
    state_next.tick    = win_end;
    state_next.pin_o   = 1'b0;
    // Latch pin held low for the clear time.
    if (state_reg.lt_f) begin
      state_next.low_cnt = 13'h0000;
    end else if (state_reg.low_cnt != 13'(oaq_pkg::LATCH_CLR_CYC)) begin
      state_next.low_cnt = state_reg.low_cnt + 13'h0001;
    end
    if (win_end) begin
      state_next.over  = is_over;
      state_next.under = is_under;
      if (!is_over) begin
        state_next.cnt = 4'h0;
      end else if (state_reg.cnt < need) begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
      if (is_over && (state_reg.cnt + 4'h1 >= need)) begin
        state_next.alert = 1'b1;
      end else if (is_under && !state_reg.latched) begin
        state_next.alert = 1'b0;
      end
    end
    // Latch mode holds the alert once raised.
    if (state_next.alert && state_reg.lt_f) begin
      state_next.latched = 1'b1;
    end
    if (state_reg.latched && !state_reg.lt_f &&
        state_reg.low_cnt == 13'(oaq_pkg::LATCH_CLR_CYC)) begin
      state_next.latched = 1'b0;
      // A window ending on this edge decides; an over window keeps the alert.
      if (win_end ? is_under : state_reg.under) begin
        state_next.alert = 1'b0;
      end
    end
    if (!state_reg.en_f) begin
      state_next.cnt     = 4'h0;
      state_next.alert   = 1'b0;
      state_next.latched = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg         <= '0;
      state_reg.en_s    <= oaq_pkg::SYNC_RST;
      state_reg.lt_s    <= oaq_pkg::SYNC_RST;
      state_reg.dl_s    <= oaq_pkg::SYNC2_RST;
      state_reg.hy_s    <= oaq_pkg::SYNC2_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign alert_n_o   = state_reg.pin_o;
  assign alert_n_oe  = state_reg.alert;
  assign window_tick = state_reg.tick;
  assign window_over = state_reg.over;
  assign over_count  = state_reg.cnt;

  sequence over_end_s;
    state_reg.tick && state_reg.over;
  endsequence

  sequence normal_end_s;
    state_reg.tick && !state_reg.over;
  endsequence

  win_tick_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg.win_cnt == 11'(oaq_pkg::WIN_CYCLES - 1) |=> state_reg.tick)
    else $error("window end not flagged");

  tick_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg.tick |=> !state_reg.tick [*8])
    else $error("window ticks too close");

  alert_at_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state_reg.alert) |-> over_end_s)
    else $error("alert rose outside an over window end");

  count_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    normal_end_s |-> state_reg.cnt == 4'h0)
    else $error("count not cleared by normal window");

  delay50_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state_reg.alert) && state_reg.dl_f == oaq_pkg::LVL_GND
    |-> state_reg.cnt == oaq_pkg::NEED_50US)
    else $error("50 us alert without five windows");

  delay100_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state_reg.alert) && state_reg.dl_f == oaq_pkg::LVL_SUPPLY
    |-> state_reg.cnt == oaq_pkg::NEED_100US)
    else $error("100 us alert without ten windows");

  release_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(state_reg.alert) && $past(state_reg.en_f) |-> state_reg.under)
    else $error("alert released above release level");

  latch_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg.latched && state_reg.lt_f && state_reg.en_f |=> state_reg.alert)
    else $error("latched alert dropped");

  disable_a: assert property (@(posedge sys_clk) disable iff (rst)
    !state_reg.en_f |=> state_reg.cnt == 4'h0 && !state_reg.alert)
    else $error("disabled part kept count or alert");

  drive_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    alert_n_o == 1'b0)
    else $error("open-drain pin driven high");

endmodule // oaq_alert_qualifier
`default_nettype wire

/* File: core/oaq_pkg.sv */
`default_nettype none
package oaq_pkg;
  // Timebase.
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned WINDOW_US      = 10;
  localparam int unsigned WIN_CYCLES     = (WINDOW_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned LATCH_CLR_US   = 20;
  localparam int unsigned LATCH_CLR_CYC  =
    (LATCH_CLR_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Three-level pin codes.
  localparam logic [1:0]  LVL_FLOAT      = 2'h0;
  localparam logic [1:0]  LVL_GND        = 2'h1;
  localparam logic [1:0]  LVL_SUPPLY     = 2'h2;
  // Consecutive over-limit windows per delay option.
  localparam logic [3:0]  NEED_10US      = 4'h1;
  localparam logic [3:0]  NEED_50US      = 4'h5;
  localparam logic [3:0]  NEED_100US     = 4'hA;
  // Hysteresis in sample units of 1 uV.
  localparam logic [17:0] HYS_2MV        = 18'h007D0;
  localparam logic [17:0] HYS_4MV        = 18'h00FA0;
  localparam logic [17:0] HYS_8MV        = 18'h01F40;
  // Reset values.
  localparam logic [2:0]  SYNC_RST       = 3'h0;
  localparam logic [5:0]  SYNC2_RST      = 6'h00;
endpackage : oaq_pkg
`default_nettype wire

/* File: bench/oaq_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module oaq_ctrl_model (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Wanted settings.
  input  wire logic       want_latch,
  input  wire logic       want_en,
  input  wire logic [1:0] want_dly,
  input  wire logic [1:0] want_hys,
  input  wire logic       clr_req,
  // Device pins and clear status.
  output logic            latch_select,
  output logic            enable_pin,
  output logic [1:0]      delay_select,
  output logic [1:0]      hysteresis_select,
  output logic            clr_busy
);
  int clr_left;
  assign clr_busy = clr_left != 0;
  always_ff @(posedge sys_clk) begin
    if (rst) clr_left <= 0;
    else if (clr_req && clr_left == 0) clr_left <= int'(oaq_pkg::LATCH_CLR_CYC) + 64;
    else if (clr_left != 0) clr_left <= clr_left - 1;
    latch_select      <= !rst && want_latch && clr_left == 0 && !clr_req;
    enable_pin        <= !rst && want_en;
    delay_select      <= want_dly;
    hysteresis_select <= want_hys;
  end
endmodule // oaq_ctrl_model
`default_nettype wire

/* File: bench/oaq_alert_qualifier_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module oaq_alert_qualifier_tb;
  logic        sys_clk, rst, want_latch, want_en, clr_req, clr_busy, b2b;
  logic [1:0]  want_dly, want_hys, delay_select, hysteresis_select;
  logic        enable_pin, latch_select, alert_n_o, alert_n_oe, window_tick, window_over;
  logic [17:0] vin_sample, limit_level;
  logic [3:0]  over_count, exp_cnt;
  logic        exp_alert, alert_pin;
  int          error_cnt, comparisons, seed;
  assign alert_pin = alert_n_oe ? alert_n_o : 1'b1;
  oaq_alert_qualifier i_dut (.sys_clk(sys_clk), .rst(rst), .vin_sample(vin_sample),
    .limit_level(limit_level), .enable_pin(enable_pin), .latch_select(latch_select),
    .delay_select(delay_select), .hysteresis_select(hysteresis_select),
    .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe), .window_tick(window_tick),
    .window_over(window_over), .over_count(over_count));
  oaq_ctrl_model i_ctrl (.sys_clk(sys_clk), .rst(rst), .want_latch(want_latch),
    .want_en(want_en), .want_dly(want_dly), .want_hys(want_hys), .clr_req(clr_req),
    .latch_select(latch_select), .enable_pin(enable_pin), .delay_select(delay_select),
    .hysteresis_select(hysteresis_select), .clr_busy(clr_busy));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [3:0] need_of(input logic [1:0] d);
    return d == 2'h1 ? oaq_pkg::NEED_50US : d == 2'h2 ? oaq_pkg::NEED_100US : oaq_pkg::NEED_10US;
  endfunction
  function automatic logic [17:0] hys_of(input logic [1:0] h);
    return h == 2'h1 ? oaq_pkg::HYS_4MV : h == 2'h2 ? oaq_pkg::HYS_8MV : oaq_pkg::HYS_2MV;
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One whole window of a kind: 0 under, 1 inside the band, 2 over.
  task automatic win(input int kind);
    int n;
    int r;
    r = $random(seed) & 1023;
    @(posedge sys_clk);
    vin_sample <= kind == 2 ? limit_level + 18'h00064 + 18'(r) : kind == 1 ?
      limit_level - (hys_of(want_hys) >> 1) : limit_level - 18'h02328 - 18'(r);
    n = 0;
    while (window_tick !== 1'b1 && n < 2100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2100) begin
      error_cnt++;
      give_verdict();
    end
    if (b2b) check("period", 18'(n), 18'(oaq_pkg::WIN_CYCLES - 1));
    if (!want_en) begin
      exp_cnt = 4'h0;
      exp_alert = 1'b0;
    end else begin
      exp_cnt = kind != 2 ? 4'h0 : exp_cnt < need_of(want_dly) ? exp_cnt + 4'h1 : exp_cnt;
      if (kind == 2 && exp_cnt == need_of(want_dly)) exp_alert = 1'b1;
      else if (kind == 0 && !want_latch) exp_alert = 1'b0;
      check("window_over", window_over, kind == 2);
    end
    check("over_count", over_count, exp_cnt);
    check("alert_oe", alert_n_oe, exp_alert);
    check("alert_pin", alert_pin, !exp_alert);
    b2b = 1'b1;
  endtask
  task automatic clear_latch(input logic still_over);
    int n;
    @(posedge sys_clk);
    clr_req <= 1'b1;
    @(posedge sys_clk);
    clr_req <= 1'b0;
    @(posedge sys_clk);
    n = 0;
    while (clr_busy && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      give_verdict();
    end
    repeat (8) @(posedge sys_clk);
    exp_alert = still_over;
    check("alert_clear", alert_n_oe, still_over);
    b2b = 1'b0;
    win(still_over ? 2 : 0);
  endtask
  initial begin
    seed = 32'h5E6A;
    {error_cnt, comparisons} = '0;
    {rst, want_en} = 2'h3;
    {want_latch, clr_req, b2b, exp_alert} = 4'h0;
    {want_dly, want_hys, exp_cnt} = 8'h00;
    vin_sample = 18'h00000;
    limit_level = 18'h0C350;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int d = 0; d < 3; d++) begin
      want_dly <= 2'(d);
      want_hys <= 2'(d);
      win(0);
      repeat (int'(need_of(2'(d)))) win(2);
      win(1);
      win(0);
      $display("delay test %0d done", d);
    end
    want_dly <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      want_hys <= 2'($random(seed));
      win(int'($unsigned($random(seed)) % 3));
    end
    $display("random test done");
    want_latch <= 1'b1;
    win(2);
    win(0);
    win(0);
    clear_latch(1'b0);
    win(2);
    want_latch <= 1'b0;
    clear_latch(1'b1);
    $display("latch test done");
    want_dly <= 2'h1;
    win(0);
    win(2);
    win(2);
    want_en <= 1'b0;
    win(2);
    want_en <= 1'b1;
    win(2);
    win(0);
    $display("disable test done");
    give_verdict();
  end
endmodule // oaq_alert_qualifier_tb
`default_nettype wire
